// ==== design/ppwc_top.sv ====
`default_nettype none
// Notes on behaviour
// RL1: power-on or D3cold exit lands in D0 uninitialized until software initializes.
// RL2: D0 runs PLL, core clock, RAM clock and codec link.
// RL3: D1 keeps state; PLL, RAM clock, link run; core clock stopped.
// RL4: return from D1 to D0 completes within 100 ms.
// RL5: D2 runs PLL and link only; return to D0 within 100 ms.
// RL6: D3hot stops PLL, both DSP clocks and the codec link.
// RL7: only D3 to D0 is allowed out of D3; host reinitializes.
// RL8: D3 to D0 write does an internal warm reset into D0 uninitialized.
// RL9: main supply gone with bus reset asserted enters D3cold at once.
// RL10: power back, reset released, wake disabled: full reset into D0 uninitialized.
// RL11: wake enabled with aux present: bus reset resets nothing during supply loss.
// RL12: wake works D0 to D3hot; in D3cold only with aux supply.
// RL13: bit clock running: dsp_core request asserts wake in any state.
// RL14: other side keeps bit clock running and link out of PR4.
// RL15: wake enabled, bit clock running: clocks at reduced rate, link runs.
// RL16: bit clock stopped: wake only from D3hot and D3cold; an enabled extended_gp_pin also wakes from D0, D1 and D2.
// RL17: link down: rising codec serial input raises wake.
// RL18: wake enabled, bit clock stopped: everything stopped.
// RL19: each extended_gp_pin individually enabled as a wake source.
// RL20: main_supply_present detects D3cold and shields logic from bus reset.
// RL21: aux_sel output moves supply to auxiliary rail.
// RL22: wake pin is active-low open-drain.
// RL23: host selects D0..D3hot via power-state field; gating follows.
// RL24: wake held until status cleared; never asserted with wake disabled.
module ppwc_top #(
	parameter int RESUME_CYCLES = ppwc_pkg::RESUME_CYC,
	parameter int EGP_W         = ppwc_pkg::EGP_W
) (
	// clock and reset
	input  wire logic              ref_clk,
	input  wire logic              rst_b,
	// bus power management
	input  wire logic              bus_rst_b,
	input  wire logic [1:0]        ps_wr_val,
	input  wire logic              ps_wr,
	input  wire logic              sw_init_done,
	input  wire logic              wake_en,
	input  wire logic              wake_sts_clr,
	// supply sensing (pins)
	input  wire logic              main_supply_present,
	input  wire logic              aux_supply_present,
	// codec link (pins)
	input  wire logic              codec_bit_clock_run,
	input  wire logic              link_down,
	input  wire logic              codec_serial_in,
	input  wire logic              second_codec_serial_in,
	// wake sources
	input  wire logic              dsp_core_wake_req,
	input  wire logic [EGP_W-1:0]  extended_gp_pin,
	input  wire logic [EGP_W-1:0]  egp_wake_en,
	// status and controls
	output ppwc_pkg::ppwc_state_t  state_o,
	output ppwc_pkg::ppwc_gate_t   gate_o,
	output logic                   warm_rst_o,
	output logic                   wake_sts_o,
	output logic                   aux_sel_o,
	output logic                   resume_busy_o,
	// wake pin, open drain
	output logic                   pme_b_o,
	output logic                   pme_oe_o
);

	////////////////////////////////////////////////////////////////////
	// pin synchronisers
	localparam int NS = 6 + EGP_W;
	logic [NS-1:0] s1_q;
	logic [NS-1:0] s2_q;
	logic [NS-1:0] s3_q;
	logic [NS-1:0] pin_raw;
	// bus reset released, main supply up: no false D3cold entry after reset
	localparam logic [NS-1:0] PIN_IDLE = NS'(6'h30);
	assign pin_raw = {extended_gp_pin, bus_rst_b, main_supply_present,
		aux_supply_present, codec_bit_clock_run, codec_serial_in,
		second_codec_serial_in};

	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			s1_q <= PIN_IDLE;
			s2_q <= PIN_IDLE;
			s3_q <= PIN_IDLE;
		end else begin
			s1_q <= pin_raw;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	logic             bus_rst_s;
	logic             main_s;
	logic             aux_s;
	logic             bclk_s;
	logic             sdi_rise;
	logic [EGP_W-1:0] egp_s;
	assign egp_s     = s2_q[NS-1:6];
	assign bus_rst_s = s2_q[5];
	assign main_s    = s2_q[4];
	assign aux_s     = s2_q[3];
	assign bclk_s    = s2_q[2];
	assign sdi_rise  = (s2_q[1] & ~s3_q[1]) | (s2_q[0] & ~s3_q[0]); // RL17

	////////////////////////////////////////////////////////////////////
	// power state machine
	ppwc_pkg::ppwc_state_t st_q;
	ppwc_pkg::ppwc_state_t st_d;
	logic [2:0]  wr_cnt_q;
	logic        shield;
	logic        cold_entry;

	// aux-powered wake: bus reset must not disturb anything
	assign shield     = wake_en & aux_s; // RL11 RL20
	assign cold_entry = !bus_rst_s && !main_s; // RL9 RL20

	always_comb begin
		st_d = st_q;
		unique case (st_q)
			ppwc_pkg::PPWC_D0_UNINIT: begin
				if (sw_init_done) begin
					st_d = ppwc_pkg::PPWC_D0_ACTIVE; // RL1
				end
			end
			ppwc_pkg::PPWC_D0_ACTIVE, ppwc_pkg::PPWC_D1, ppwc_pkg::PPWC_D2: begin
				if (ps_wr) begin
					unique case (ps_wr_val) // RL23
						ppwc_pkg::PS_D0: st_d = ppwc_pkg::PPWC_D0_ACTIVE;
						ppwc_pkg::PS_D1: st_d = ppwc_pkg::PPWC_D1;
						ppwc_pkg::PS_D2: st_d = ppwc_pkg::PPWC_D2;
						ppwc_pkg::PS_D3: st_d = ppwc_pkg::PPWC_D3_HOT;
					endcase
				end
			end
			ppwc_pkg::PPWC_D3_HOT: begin
				if (ps_wr && ps_wr_val == ppwc_pkg::PS_D0) begin
					st_d = ppwc_pkg::PPWC_WARM_RST; // RL7 RL8
				end
			end
			ppwc_pkg::PPWC_D3_COLD: begin
				if (main_s && bus_rst_s) begin
					st_d = ppwc_pkg::PPWC_D0_UNINIT; // RL1 RL10
				end
			end
			ppwc_pkg::PPWC_WARM_RST: begin
				if (wr_cnt_q == 3'(ppwc_pkg::WARM_RST_CYC - 1)) begin
					st_d = ppwc_pkg::PPWC_D0_UNINIT; // RL8
				end
			end
			default: st_d = ppwc_pkg::PPWC_D0_UNINIT;
		endcase
		if (cold_entry) begin
			st_d = ppwc_pkg::PPWC_D3_COLD; // RL9
		end else if (!bus_rst_s && !shield) begin
			st_d = ppwc_pkg::PPWC_D0_UNINIT; // RL10
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			st_q <= ppwc_pkg::PPWC_D0_UNINIT; // RL1
		end else begin
			st_q <= st_d;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_b || st_q != ppwc_pkg::PPWC_WARM_RST) begin
			wr_cnt_q <= '0;
		end else begin
			wr_cnt_q <= wr_cnt_q + 3'h1;
		end
	end

	////////////////////////////////////////////////////////////////////
	// resume timer from D1/D2
	logic [$clog2(RESUME_CYCLES+1)-1:0] res_cnt_q;
	logic                               from_sleep;
	assign from_sleep = (st_q == ppwc_pkg::PPWC_D1 || st_q == ppwc_pkg::PPWC_D2)
		&& st_d == ppwc_pkg::PPWC_D0_ACTIVE;

	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			res_cnt_q <= '0;
		end else if (from_sleep) begin
			// a short restart well inside the limit
			res_cnt_q <= ($clog2(RESUME_CYCLES+1))'(ppwc_pkg::WARM_RST_CYC); // RL4 RL5
		end else if (res_cnt_q != '0) begin
			res_cnt_q <= res_cnt_q - 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////
	// clock gating
	function automatic ppwc_pkg::ppwc_gate_t gate_of(
		input ppwc_pkg::ppwc_state_t s,
		input logic we,
		input logic bc
	);
		ppwc_pkg::ppwc_gate_t g;
		g = ppwc_pkg::GATE_ALL_OFF;
		unique case (s)
			ppwc_pkg::PPWC_D0_UNINIT, ppwc_pkg::PPWC_D0_ACTIVE: g = ppwc_pkg::GATE_ALL_ON; // RL2
			ppwc_pkg::PPWC_D1: g = ppwc_pkg::GATE_D1; // RL3
			ppwc_pkg::PPWC_D2: g = ppwc_pkg::GATE_D2; // RL5
			ppwc_pkg::PPWC_D3_HOT, ppwc_pkg::PPWC_D3_COLD,
			ppwc_pkg::PPWC_WARM_RST: g = ppwc_pkg::GATE_ALL_OFF; // RL6 RL9
		endcase
		if (we && (s == ppwc_pkg::PPWC_D3_HOT || s == ppwc_pkg::PPWC_D3_COLD)) begin
			g = bc ? ppwc_pkg::GATE_REDUCED : ppwc_pkg::GATE_ALL_OFF; // RL15 RL18
		end
		return g;
	endfunction : gate_of

	ppwc_pkg::ppwc_gate_t gate_q;
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			gate_q <= ppwc_pkg::GATE_ALL_ON;
		end else begin
			gate_q <= gate_of(st_d, wake_en, bclk_s);
		end
	end

	////////////////////////////////////////////////////////////////////
	// wake event and status
	logic wake_ok;
	logic wake_evt;
	logic in_d3;
	logic sts_q;
	logic egp_hit;
	assign in_d3   = st_q == ppwc_pkg::PPWC_D3_HOT || st_q == ppwc_pkg::PPWC_D3_COLD;
	assign wake_ok = wake_en && (st_q != ppwc_pkg::PPWC_D3_COLD || aux_s); // RL12
	assign egp_hit = |(egp_s & egp_wake_en); // RL19
	assign wake_evt = wake_ok && (
		(bclk_s && dsp_core_wake_req) || // RL13 RL14
		(!bclk_s && in_d3 && link_down && sdi_rise) || // RL16 RL17
		egp_hit);

	always_ff @(posedge ref_clk) begin
		if (!rst_b || !wake_en) begin
			sts_q <= 1'b0; // RL24
		end else if (wake_evt) begin
			sts_q <= 1'b1; // RL24
		end else if (wake_sts_clr) begin
			sts_q <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////
	// registered outputs
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			pme_oe_o      <= 1'b0;
			pme_b_o       <= 1'b0;
			aux_sel_o     <= 1'b0;
			state_o       <= ppwc_pkg::PPWC_D0_UNINIT;
			warm_rst_o    <= 1'b0;
			wake_sts_o    <= 1'b0;
			resume_busy_o <= 1'b0;
		end else begin
			pme_oe_o      <= sts_q && wake_en; // RL22 RL24
			pme_b_o       <= 1'b0; // RL22
			aux_sel_o     <= !main_s && aux_s && wake_en; // RL21
			state_o       <= st_q;
			warm_rst_o    <= st_q == ppwc_pkg::PPWC_WARM_RST; // RL8
			wake_sts_o    <= sts_q;
			resume_busy_o <= res_cnt_q != '0;
		end
	end
	assign gate_o = gate_q;

	////////////////////////////////////////////////////////////////////
	// checks
	sequence sleep_to_d0_s;
		(st_q == ppwc_pkg::PPWC_D1 || st_q == ppwc_pkg::PPWC_D2) && from_sleep;
	endsequence

	d3_exit_only_d0_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // RL7
		st_q == ppwc_pkg::PPWC_D3_HOT |=> st_q inside {ppwc_pkg::PPWC_D3_HOT,
			ppwc_pkg::PPWC_WARM_RST, ppwc_pkg::PPWC_D3_COLD, ppwc_pkg::PPWC_D0_UNINIT})
		else $error("illegal exit from D3hot");
	warm_rst_end_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // RL8
		$rose(st_q == ppwc_pkg::PPWC_WARM_RST) && bus_rst_s && main_s
		##0 (bus_rst_s && main_s) [*4] |=> st_q == ppwc_pkg::PPWC_D0_UNINIT)
		else $error("warm reset did not end in D0 uninitialized");
	cold_entry_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // RL9
		cold_entry |=> st_q == ppwc_pkg::PPWC_D3_COLD)
		else $error("D3cold not entered");
	d0_gate_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // RL2
		st_q == ppwc_pkg::PPWC_D0_ACTIVE && !$rose(st_q == ppwc_pkg::PPWC_D0_ACTIVE)
		|-> gate_o == ppwc_pkg::GATE_ALL_ON)
		else $error("D0 clocks not all running");
	d1_gate_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // RL3
		$past(st_d) == ppwc_pkg::PPWC_D1 |-> !gate_o.core_clk_run && gate_o.ram_clk_run)
		else $error("D1 gating wrong");
	resume_bound_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // RL4
		sleep_to_d0_s |-> ##2 resume_busy_o ##[1:8] !resume_busy_o)
		else $error("resume from sleep too slow");
	pme_needs_en_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // RL24
		pme_oe_o |-> $past(wake_en))
		else $error("wake driven while disabled");
	pme_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // RL24
		sts_q && !wake_sts_clr && wake_en |=> sts_q)
		else $error("wake status dropped without clear");
	dsp_wake_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // RL13
		wake_en && bclk_s && dsp_core_wake_req && st_q != ppwc_pkg::PPWC_D3_COLD
		##1 wake_en |-> ##1 pme_oe_o)
		else $error("dsp_core wake not raised");
	no_sleep_wake_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // RL16
		!bclk_s && (st_q == ppwc_pkg::PPWC_D1 || st_q == ppwc_pkg::PPWC_D2) && !egp_hit
		|-> !wake_evt)
		else $error("wake raised from D1 or D2 with bit clock stopped");

	// gating per state, then warm reset, aux rail, wake pin, wake source and bus reset shield checks
	d2_gate_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // RL5
		$past(st_d) == ppwc_pkg::PPWC_D2 |-> gate_o == ppwc_pkg::GATE_D2)
		else $error("D2 gating wrong");
	d3_gate_off_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // RL6 RL9 RL18
		$past(st_d) inside {ppwc_pkg::PPWC_D3_HOT, ppwc_pkg::PPWC_D3_COLD}
		&& !($past(wake_en) && $past(bclk_s)) |-> gate_o == ppwc_pkg::GATE_ALL_OFF)
		else $error("D3 clocks not stopped");
	reduced_rate_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // RL15
		$past(st_d) inside {ppwc_pkg::PPWC_D3_HOT, ppwc_pkg::PPWC_D3_COLD}
		&& $past(wake_en) && $past(bclk_s) |-> gate_o == ppwc_pkg::GATE_REDUCED)
		else $error("reduced-rate gating wrong");
	warm_flag_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // RL8
		st_q == ppwc_pkg::PPWC_WARM_RST |=> warm_rst_o)
		else $error("warm reset not flagged");
	aux_switch_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // RL21
		!main_s && aux_s && wake_en |=> aux_sel_o)
		else $error("aux rail not selected");
	pme_level_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // RL22
		pme_oe_o |-> !pme_b_o)
		else $error("wake pin driven high");
	serial_wake_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // RL17
		wake_en && !bclk_s && link_down && sdi_rise && st_q == ppwc_pkg::PPWC_D3_HOT |=> sts_q)
		else $error("codec serial wake missed");
	gp_wake_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // RL19
		wake_en && (egp_s & egp_wake_en) != '0 && st_q != ppwc_pkg::PPWC_D3_COLD |=> sts_q)
		else $error("pin wake missed");
	shield_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // RL11
		shield && main_s && !bus_rst_s && st_q == ppwc_pkg::PPWC_D3_HOT && !ps_wr
		|=> st_q == ppwc_pkg::PPWC_D3_HOT)
		else $error("bus reset disturbed shielded state");

endmodule : ppwc_top
`default_nettype wire

// ==== inc/ppwc_pkg.sv ====
`default_nettype none
package ppwc_pkg;
	// power-state field encodings
	localparam logic [1:0] PS_D0 = 2'h0;
	localparam logic [1:0] PS_D1 = 2'h1;
	localparam logic [1:0] PS_D2 = 2'h2;
	localparam logic [1:0] PS_D3 = 2'h3;

	// timing and extended pin width
	localparam int CLK_HZ       = 10_000_000;
	localparam int RESUME_MS    = 100;
	localparam int RESUME_CYC   = (CLK_HZ / 1000) * RESUME_MS;
	localparam int WARM_RST_CYC = 4;
	localparam int EGP_W        = 8;

	typedef enum logic [2:0] {
		PPWC_D0_UNINIT,
		PPWC_D0_ACTIVE,
		PPWC_D1,
		PPWC_D2,
		PPWC_D3_HOT,
		PPWC_D3_COLD,
		PPWC_WARM_RST
	} ppwc_state_t;

	typedef struct packed {
		logic pll_run;
		logic core_clk_run;
		logic ram_clk_run;
		logic link_run;
		logic reduced_rate;
	} ppwc_gate_t;

	localparam ppwc_gate_t GATE_ALL_ON  = 5'h1E;
	localparam ppwc_gate_t GATE_D1      = 5'h16;
	localparam ppwc_gate_t GATE_D2      = 5'h12;
	localparam ppwc_gate_t GATE_ALL_OFF = 5'h00;
	localparam ppwc_gate_t GATE_REDUCED = 5'h1F;
endpackage : ppwc_pkg
`default_nettype wire

// ==== verif/ppwc_partner.sv ====
`default_nettype none
module ppwc_partner (
	// clock
	input  wire logic ref_clk,
	// bus reset and supply sense
	output var logic  bus_rst_b,
	output var logic  main_supply_present,
	output var logic  aux_supply_present,
	// codec link
	output var logic  codec_bit_clock_run,
	output var logic  link_down,
	output var logic  codec_serial_in,
	output var logic  second_codec_serial_in
);
	timeunit 1ns;
	timeprecision 1ns;

	initial begin
		bus_rst_b = 1'b1;
		main_supply_present = 1'b1;
		aux_supply_present = 1'b1;
		codec_bit_clock_run = 1'b1;
		link_down = 1'b0;
		codec_serial_in = 1'b0;
		second_codec_serial_in = 1'b0;
	end

	// supply loss always comes with bus reset
	task automatic supply(input logic main, input logic aux);
		@(posedge ref_clk);
		aux_supply_present <= aux;
		main_supply_present <= main;
		bus_rst_b <= 1'b0;
		if (main) begin
			repeat (3) @(posedge ref_clk);
			bus_rst_b <= 1'b1;
		end
	endtask : supply

	// link only goes down with the bit clock stopped
	task automatic link(input logic run);
		@(posedge ref_clk);
		codec_bit_clock_run <= run;
		link_down <= ~run;
	endtask : link

	task automatic serial_rise(input logic second);
		@(posedge ref_clk);
		if (second)
			second_codec_serial_in <= 1'b1;
		else
			codec_serial_in <= 1'b1;
		repeat (3) @(posedge ref_clk);
		codec_serial_in <= 1'b0;
		second_codec_serial_in <= 1'b0;
	endtask : serial_rise
endmodule : ppwc_partner
`default_nettype wire

// ==== verif/tb_top.sv ====
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic ref_clk = 1'b0, rst_b = 1'b0, ps_wr = 1'b0, sw_init_done = 1'b0, wake_en = 1'b0;
	logic wake_sts_clr = 1'b0, dsp_core_wake_req = 1'b0, warm_seen = 1'b0;
	logic [1:0] ps_wr_val = 2'h0;
	logic [7:0] extended_gp_pin = 8'h00, egp_wake_en = 8'h00;
	wire logic bus_rst_b, main_supply_present, aux_supply_present, codec_bit_clock_run;
	wire logic link_down, codec_serial_in, second_codec_serial_in;
	ppwc_pkg::ppwc_state_t state_o, m_st = ppwc_pkg::PPWC_D0_UNINIT;
	ppwc_pkg::ppwc_gate_t gate_o;
	logic warm_rst_o, wake_sts_o, aux_sel_o, resume_busy_o, pme_b_o, pme_oe_o;
	int failures = 0, tests_run = 0, cyc = 0, idx;

	ppwc_top #(.RESUME_CYCLES(200), .EGP_W(8)) dut (.ref_clk, .rst_b, .bus_rst_b, .ps_wr_val,
		.ps_wr, .sw_init_done, .wake_en, .wake_sts_clr, .main_supply_present,
		.aux_supply_present, .codec_bit_clock_run, .link_down, .codec_serial_in,
		.second_codec_serial_in, .dsp_core_wake_req, .extended_gp_pin, .egp_wake_en,
		.state_o, .gate_o, .warm_rst_o, .wake_sts_o, .aux_sel_o, .resume_busy_o, .pme_b_o,
		.pme_oe_o);
	ppwc_partner partner (.ref_clk, .bus_rst_b, .main_supply_present, .aux_supply_present,
		.codec_bit_clock_run, .link_down, .codec_serial_in, .second_codec_serial_in);

	always #50 ref_clk = ~ref_clk;
	always @(posedge ref_clk) begin
		cyc++;
		if (warm_rst_o === 1'b1)
			warm_seen <= 1'b1;
		if (cyc == 20000) begin
			failures++;
			print_verdict();
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : print_verdict

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp) begin
			failures++;
			$display("[FAIL] t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	function automatic ppwc_pkg::ppwc_gate_t exp_gate();
		case (m_st)
			ppwc_pkg::PPWC_D1: return ppwc_pkg::GATE_D1;
			ppwc_pkg::PPWC_D2: return ppwc_pkg::GATE_D2;
			ppwc_pkg::PPWC_D3_HOT, ppwc_pkg::PPWC_D3_COLD: begin
				if (wake_en && codec_bit_clock_run)
					return ppwc_pkg::GATE_REDUCED;
				return ppwc_pkg::GATE_ALL_OFF;
			end
			default: return ppwc_pkg::GATE_ALL_ON;
		endcase
	endfunction : exp_gate

	task automatic cmp_st();
		check({5'h00, state_o}, {5'h00, m_st});
		check({3'h0, gate_o}, {3'h0, exp_gate()});
	endtask : cmp_st

	task automatic wr_ps(input logic [1:0] v);
		@(posedge ref_clk);
		ps_wr <= 1'b1;
		ps_wr_val <= v;
		@(posedge ref_clk);
		ps_wr <= 1'b0;
		if (m_st == ppwc_pkg::PPWC_D3_HOT) begin
			if (v == ppwc_pkg::PS_D0)
				m_st = ppwc_pkg::PPWC_D0_UNINIT;
		end else if (m_st != ppwc_pkg::PPWC_D0_UNINIT)
			m_st = ppwc_pkg::ppwc_state_t'(3'(v) + 3'h1);
		repeat (10) @(posedge ref_clk);
	endtask : wr_ps

	task automatic init_sw();
		@(posedge ref_clk);
		sw_init_done <= 1'b1;
		@(posedge ref_clk);
		sw_init_done <= 1'b0;
		repeat (3) @(posedge ref_clk);
		if (m_st == ppwc_pkg::PPWC_D0_UNINIT)
			m_st = ppwc_pkg::PPWC_D0_ACTIVE;
	endtask : init_sw

	task automatic clr_wake();
		repeat (4) @(posedge ref_clk);
		wake_sts_clr <= 1'b1;
		@(posedge ref_clk);
		wake_sts_clr <= 1'b0;
	endtask : clr_wake

	task automatic dsp_req();
		dsp_core_wake_req <= 1'b1;
		repeat (2) @(posedge ref_clk);
		dsp_core_wake_req <= 1'b0;
	endtask : dsp_req

	task automatic chk_pme(input logic exp);
		repeat (6) @(posedge ref_clk);
		check({7'h00, pme_oe_o}, {7'h00, exp});
		check({7'h00, wake_sts_o}, {7'h00, exp});
	endtask : chk_pme

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		void'($urandom(10));
		repeat (12) @(posedge ref_clk);
		rst_b <= 1'b1;
		repeat (4) @(posedge ref_clk);
		cmp_st();
		check({6'h00, pme_b_o, aux_sel_o}, 8'h00);
		wr_ps(ppwc_pkg::PS_D1);
		cmp_st();
		init_sw();
		cmp_st();
		for (int v = 1; v < 3; v++) begin
			wr_ps(2'(v));
			cmp_st();
			wr_ps(ppwc_pkg::PS_D0);
			cmp_st();
			check({7'h00, resume_busy_o}, 8'h00);
		end
		wr_ps(ppwc_pkg::PS_D3);
		cmp_st();
		wr_ps(ppwc_pkg::PS_D1);
		cmp_st();
		wr_ps(ppwc_pkg::PS_D0);
		cmp_st();
		check({7'h00, warm_seen}, 8'h01);
		init_sw();
		wake_en <= 1'b1;
		for (int v = 0; v < 4; v++) begin
			wr_ps(2'(v));
			cmp_st();
			dsp_req();
			chk_pme(1'b1);
			clr_wake();
			chk_pme(1'b0);
			wr_ps(ppwc_pkg::PS_D0);
			init_sw();
		end
		wake_en <= 1'b0;
		dsp_req();
		chk_pme(1'b0);
		wake_en <= 1'b1;
		partner.link(1'b0);
		wr_ps(ppwc_pkg::PS_D1);
		partner.serial_rise(1'b0);
		chk_pme(1'b0);
		wr_ps(ppwc_pkg::PS_D0);
		wr_ps(ppwc_pkg::PS_D3);
		cmp_st();
		for (int i = 0; i < 2; i++) begin
			partner.serial_rise(i[0]);
			chk_pme(1'b1);
			clr_wake();
			chk_pme(1'b0);
		end
		idx = $urandom_range(7);
		egp_wake_en <= 8'h01 << idx;
		extended_gp_pin <= 8'($urandom()) & ~(8'h01 << idx);
		chk_pme(1'b0);
		extended_gp_pin[idx] <= 1'b1;
		chk_pme(1'b1);
		extended_gp_pin <= 8'h00;
		clr_wake();
		chk_pme(1'b0);
		wake_en <= 1'b0;
		partner.link(1'b1);
		partner.supply(1'b0, 1'b1);
		m_st = ppwc_pkg::PPWC_D3_COLD;
		repeat (6) @(posedge ref_clk);
		cmp_st();
		check({7'h00, aux_sel_o}, 8'h00);
		partner.supply(1'b1, 1'b1);
		m_st = ppwc_pkg::PPWC_D0_UNINIT;
		repeat (6) @(posedge ref_clk);
		cmp_st();
		init_sw();
		wake_en <= 1'b1;
		wr_ps(ppwc_pkg::PS_D3);
		partner.supply(1'b1, 1'b1);
		repeat (6) @(posedge ref_clk);
		cmp_st();
		partner.supply(1'b0, 1'b1);
		m_st = ppwc_pkg::PPWC_D3_COLD;
		repeat (6) @(posedge ref_clk);
		cmp_st();
		check({7'h00, aux_sel_o}, 8'h01);
		dsp_req();
		chk_pme(1'b1);
		print_verdict();
	end
endmodule : tb_top
`default_nettype wire
